// *** dcr_defines.svh ***
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH
// Behaviour
// - Nonzero ratio reference beats hertz reference
// - Nonzero hertz reference beats speed reference
// - Ratio reference: plus/minus 20000 equals maximum
// - Accept any ratio, clamp resulting frequency
// - Optionally treat negative PID setpoint as zero
// - Reads return last written command value
// - Run word bit 15 high-then-low clears fault
// - Run word clear needs link control enabled
// - Fault-clear write one pulses timed reset
// - Fault-clear reads zero, always honoured
// - Input bits trigger their assigned functions
// - Stop-hold function refused from the link
// - Ramp select high: link only, default off
// - Link enable: terminal only, default on

// ****************************************
// Register indices on the link
// ****************************************
`define DCR_IDX_FREQ_RATIO  8'h01
`define DCR_IDX_FREQ_HZ     8'h05
`define DCR_IDX_RUN_WORD    8'h06
`define DCR_IDX_PID         8'h0d
`define DCR_IDX_FAULT_CLEAR 8'h0e
`define DCR_IDX_SPEED       8'h13

// ****************************************
// Fields, values and timing
// ****************************************
`define DCR_REG_RESET       16'h0000
`define DCR_RUN_FWD_BIT     0
`define DCR_RUN_REV_BIT     1
`define DCR_RUN_GP_LSB      2
`define DCR_RUN_GP_MSB      12
`define DCR_RUN_FAULT_BIT   15
`define DCR_FAULT_CLEAR_VAL 16'h0001
`define DCR_RATIO_FULL      33'sd20000
`define DCR_FUNC_RAMP_HIGH  5
`define DCR_FUNC_STOP_HOLD  6
`define DCR_FUNC_LINK_EN    24
`define DCR_CLK_PERIOD_NS   4
`define DCR_FAULT_CLEAR_NS  10000
`define DCR_FAULT_CLEAR_CYC \
    ((`DCR_FAULT_CLEAR_NS + `DCR_CLK_PERIOD_NS - 1) / `DCR_CLK_PERIOD_NS)
`endif

// *** dcr_pkg.sv ***
package dcr_pkg;

    // ****************************************
    // Reference source in use
    // ****************************************
    typedef enum logic [1:0] {
        DCR_SRC_RATIO = 2'b00,
        DCR_SRC_HZ    = 2'b01,
        DCR_SRC_SPEED = 2'b10
    } dcr_src_e;

    // One link write
    typedef struct packed {
        logic        valid;
        logic [7:0]  index;
        logic [15:0] data;
    } dcr_wr_s;

    // Drive configuration settings
    typedef struct packed {
        logic        link_function_setting;
        logic        bus_function_setting;
        logic        loader_link_setting;
        logic [15:0] max_freq;
        logic [15:0] upper_limit;
    } dcr_cfg_s;

    // Effective references for the drive core
    typedef struct packed {
        dcr_src_e           src;
        logic signed [16:0] freq;
        logic [15:0]        speed;
        logic [15:0]        pid;
    } dcr_drive_s;

endpackage

// *** dcr_func_map.sv ***
`timescale 1ns/1ps
module dcr_func_map #(
    parameter int NBITS = 11,
    parameter int CW    = 8,
    parameter int NFUNC = 64
) (
    // Input bits and their assignment codes
    input  wire logic [NBITS-1:0][CW-1:0] codes_i,
    input  wire logic [NBITS-1:0]         bits_i,
    input  wire logic [NFUNC-1:0]         mask_i,
    // Decoded functions
    output logic      [NFUNC-1:0]         active_o,
    output logic      [NFUNC-1:0]         assigned_o
);
    import dcr_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (NBITS < 1 || NFUNC < 25 || NFUNC > (1 << CW))
        $error("dcr_func_map: unsupported parameters");

    // Code match, used for both outputs
    function automatic logic code_is(input logic [CW-1:0] c, input int f);
        code_is = (c == f[CW-1:0]);
    endfunction

    // ****************************************
    // One decoder per function
    // ****************************************
    for (genvar f = 0; f < NFUNC; f++)
    begin : g_func
        logic hit;
        logic used;
        always_comb
        begin
            hit  = 1'b0;
            used = 1'b0;
            for (int b = 0; b < NBITS; b++)
            begin
                used = used | code_is(codes_i[b], f);
                hit  = hit | (code_is(codes_i[b], f) & bits_i[b]);
            end
        end
        // Masked functions never show as active
        assign active_o[f]   = hit & mask_i[f];
        assign assigned_o[f] = used;
    end
endmodule

// *** dcr_fault_pulse.sv ***
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_fault_pulse #(
    parameter int CYCLES = `DCR_FAULT_CLEAR_CYC
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic reset_i,
    // Request and timed pulse
    input  wire logic start_i,
    output logic      active_o
);
    import dcr_pkg::*;

    localparam int CNTW = $clog2(CYCLES + 1);

    if (CYCLES < 1)
        $error("dcr_fault_pulse: CYCLES must be at least one");

    typedef enum logic {
        DCR_PULSE_IDLE = 1'b0,
        DCR_PULSE_HOLD = 1'b1
    } dcr_pulse_e;

    dcr_pulse_e      state_reg;
    logic [CNTW-1:0] count_reg;

    // ****************************************
    // Reset command held for a fixed time
    // ****************************************
    // A new request restarts the full interval
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg <= DCR_PULSE_IDLE;
            count_reg <= '0;
        end
        else if (start_i)
        begin
            state_reg <= DCR_PULSE_HOLD;
            count_reg <= CNTW'(CYCLES - 1);
        end
        else
        begin
            unique case (state_reg)
                DCR_PULSE_IDLE: count_reg <= '0;
                DCR_PULSE_HOLD:
                begin
                    if (count_reg == '0)
                        state_reg <= DCR_PULSE_IDLE;
                    else
                        count_reg <= count_reg - 1'b1;
                end
            endcase
        end
    end

    assign active_o = (state_reg == DCR_PULSE_HOLD);

    // Pulse ends by itself when the count runs out
    a_pulse_self_ends: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (active_o && count_reg == '0 && !start_i) |=> !active_o)
        else $error("fault clear pulse did not end");
endmodule

// *** dcr_top.sv ***
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_top #(
    parameter int  NBITS        = 11,
    parameter int  NFUNC        = 64,
    parameter int  CLEAR_CYCLES = `DCR_FAULT_CLEAR_CYC,
    parameter bit  PID_NEG_ZERO = 1'b1
) (
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   reset_i,
    // Link register access
    input  wire dcr_pkg::dcr_wr_s       wr_i,
    input  wire logic                   rd_req_i,
    input  wire logic [7:0]             rd_index_i,
    output logic      [15:0]            rdata_o,
    output logic                        rd_ack_o,
    // Configuration and terminal block
    input  wire dcr_pkg::dcr_cfg_s      cfg_i,
    input  wire logic [NBITS-1:0][7:0]  codes_i,
    input  wire logic [NBITS-1:0]       terminal_i,
    // Commands to the drive core
    output dcr_pkg::dcr_drive_s         drive_o,
    output logic                        forward_run_bit_o,
    output logic                        reverse_run_bit_o,
    output logic      [NFUNC-1:0]       func_o,
    output logic                        link_control_enable_o,
    output logic                        fault_clear_o
);
    import dcr_pkg::*;

    if (NBITS != `DCR_RUN_GP_MSB - `DCR_RUN_GP_LSB + 1 || NFUNC < 25)
        $error("dcr_top: input bit count must match the run word");

    // Write hit on one register index
    function automatic logic wr_hit(input dcr_wr_s w, input logic [7:0] idx);
        wr_hit = w.valid && (w.index == idx);
    endfunction

    // ****************************************
    // Command registers
    // ****************************************
    logic [15:0] frequency_ratio_cmd_reg;
    logic [15:0] frequency_hz_cmd_reg;
    logic [15:0] pid_setpoint_cmd_reg;
    logic [15:0] speed_rpm_cmd_reg;
    logic [15:0] run_command_word_reg;
    logic        link_ctrl_reg;

    // Values stored as written; clamping happens downstream only
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            frequency_ratio_cmd_reg <= `DCR_REG_RESET;
            frequency_hz_cmd_reg    <= `DCR_REG_RESET;
            pid_setpoint_cmd_reg    <= `DCR_REG_RESET;
            speed_rpm_cmd_reg       <= `DCR_REG_RESET;
            run_command_word_reg    <= `DCR_REG_RESET;
        end
        else
        begin
            if (wr_hit(wr_i, `DCR_IDX_FREQ_RATIO))
                frequency_ratio_cmd_reg <= wr_i.data;
            if (wr_hit(wr_i, `DCR_IDX_FREQ_HZ))
                frequency_hz_cmd_reg <= wr_i.data;
            if (wr_hit(wr_i, `DCR_IDX_PID))
                pid_setpoint_cmd_reg <= wr_i.data;
            if (wr_hit(wr_i, `DCR_IDX_SPEED))
                speed_rpm_cmd_reg <= wr_i.data;
            if (wr_hit(wr_i, `DCR_IDX_RUN_WORD))
                run_command_word_reg <= wr_i.data;
        end
    end

    // ****************************************
    // Read back
    // ****************************************
    logic [15:0] rdata_next;

    // Shows what the host wrote, never the clamped value
    always_comb
    begin
        unique case (rd_index_i)
            `DCR_IDX_FREQ_RATIO:  rdata_next = frequency_ratio_cmd_reg;
            `DCR_IDX_FREQ_HZ:     rdata_next = frequency_hz_cmd_reg;
            `DCR_IDX_PID:         rdata_next = pid_setpoint_cmd_reg;
            `DCR_IDX_SPEED:       rdata_next = speed_rpm_cmd_reg;
            `DCR_IDX_RUN_WORD:    rdata_next = run_command_word_reg;
            `DCR_IDX_FAULT_CLEAR: rdata_next = 16'h0000;
            default:              rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_o  <= 16'h0000;
            rd_ack_o <= 1'b0;
        end
        else
        begin
            rd_ack_o <= rd_req_i;
            if (rd_req_i)
                rdata_o <= rdata_next;
        end
    end

    // ****************************************
    // Fault clear requests
    // ****************************************
    logic run_clear_req;
    logic cmd_clear_req;

    // Falling bit 15 on a run word write, only under link control
    assign run_clear_req = wr_hit(wr_i, `DCR_IDX_RUN_WORD)
                         && run_command_word_reg[`DCR_RUN_FAULT_BIT]
                         && !wr_i.data[`DCR_RUN_FAULT_BIT]
                         && link_ctrl_reg;
    // Direct command ignores every link enable setting
    assign cmd_clear_req = wr_hit(wr_i, `DCR_IDX_FAULT_CLEAR)
                         && (wr_i.data == `DCR_FAULT_CLEAR_VAL);

    dcr_fault_pulse #(
        .CYCLES   (CLEAR_CYCLES)
    ) u_pulse (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .start_i  (run_clear_req | cmd_clear_req),
        .active_o (fault_clear_o)
    );

    // ****************************************
    // Terminal function decoding
    // ****************************************
    logic [NFUNC-1:0] link_mask;
    logic [NFUNC-1:0] term_mask;
    logic [NFUNC-1:0] link_active;
    logic [NFUNC-1:0] term_active;
    logic [NFUNC-1:0] term_assigned;

    // Stop-hold and link enable never come from the link word
    always_comb
    begin
        link_mask = '1;
        link_mask[`DCR_FUNC_STOP_HOLD] = 1'b0;
        link_mask[`DCR_FUNC_LINK_EN]   = 1'b0;
        term_mask = '1;
        term_mask[`DCR_FUNC_RAMP_HIGH] = 1'b0;
    end

    dcr_func_map #(
        .NBITS      (NBITS),
        .CW         (8),
        .NFUNC      (NFUNC)
    ) u_link_map (
        .codes_i    (codes_i),
        .bits_i     (run_command_word_reg[`DCR_RUN_GP_MSB:`DCR_RUN_GP_LSB]),
        .mask_i     (link_mask),
        .active_o   (link_active),
        .assigned_o ()
    );

    dcr_func_map #(
        .NBITS      (NBITS),
        .CW         (8),
        .NFUNC      (NFUNC)
    ) u_term_map (
        .codes_i    (codes_i),
        .bits_i     (terminal_i),
        .mask_i     (term_mask),
        .active_o   (term_active),
        .assigned_o (term_assigned)
    );

    // ****************************************
    // Link control and function outputs
    // ****************************************
    logic le_eff;
    logic link_ctrl_next;

    // Unassigned link enable counts as on
    assign le_eff = term_assigned[`DCR_FUNC_LINK_EN]
                  ? term_active[`DCR_FUNC_LINK_EN] : 1'b1;
    assign link_ctrl_next = cfg_i.link_function_setting
                          && cfg_i.bus_function_setting
                          && cfg_i.loader_link_setting
                          && le_eff;

    // Link bits count only while the link has control
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            link_ctrl_reg     <= 1'b0;
            func_o            <= '0;
            forward_run_bit_o <= 1'b0;
            reverse_run_bit_o <= 1'b0;
        end
        else
        begin
            link_ctrl_reg <= link_ctrl_next;
            func_o        <= term_active
                           | (link_ctrl_reg ? link_active : '0);
            forward_run_bit_o <= link_ctrl_reg
                               & run_command_word_reg[`DCR_RUN_FWD_BIT];
            reverse_run_bit_o <= link_ctrl_reg
                               & run_command_word_reg[`DCR_RUN_REV_BIT];
        end
    end

    assign link_control_enable_o = link_ctrl_reg;

    // ****************************************
    // Reference scaling and selection
    // ****************************************
    logic [15:0]        limit_w;
    logic signed [32:0] ratio_prod;
    logic signed [32:0] ratio_scaled;
    logic signed [32:0] limit_s;
    logic signed [16:0] ratio_freq;
    logic [15:0]        hz_clamped;
    dcr_drive_s         drive_next;

    // Tighter of maximum and upper limit bounds the ratio and hertz sources
    assign limit_w = (cfg_i.upper_limit < cfg_i.max_freq)
                   ? cfg_i.upper_limit : cfg_i.max_freq;
    assign limit_s = $signed({17'h00000, limit_w});
    // Full scale of the ratio maps onto the maximum frequency
    assign ratio_prod   = $signed(frequency_ratio_cmd_reg)
                        * $signed({1'b0, cfg_i.max_freq});
    assign ratio_scaled = ratio_prod / `DCR_RATIO_FULL;

    always_comb
    begin
        if (ratio_scaled > limit_s)
            ratio_freq = limit_s[16:0];
        else if (ratio_scaled < -limit_s)
            ratio_freq = 17'(-limit_s);
        else
            ratio_freq = ratio_scaled[16:0];
        hz_clamped = (frequency_hz_cmd_reg > limit_w)
                   ? limit_w : frequency_hz_cmd_reg;
    end

    // Nonzero ratio first, then nonzero hertz, then speed
    always_comb
    begin
        drive_next.speed = speed_rpm_cmd_reg;
        if (frequency_ratio_cmd_reg != 16'h0000)
        begin
            drive_next.src  = DCR_SRC_RATIO;
            drive_next.freq = ratio_freq;
        end
        else if (frequency_hz_cmd_reg != 16'h0000)
        begin
            drive_next.src  = DCR_SRC_HZ;
            drive_next.freq = $signed({1'b0, hz_clamped});
        end
        else
        begin
            drive_next.src  = DCR_SRC_SPEED;
            drive_next.freq = 17'sh00000;
        end
        // Some variants cannot run negative PID setpoints
        if (PID_NEG_ZERO && pid_setpoint_cmd_reg[15])
            drive_next.pid = 16'h0000;
        else
            drive_next.pid = pid_setpoint_cmd_reg;
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            drive_o <= '{src: DCR_SRC_SPEED, freq: 17'sh00000,
                         speed: 16'h0000, pid: 16'h0000};
        else
            drive_o <= drive_next;
    end

    // ****************************************
    // Checks
    // ****************************************
    a_ratio_wins: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (frequency_ratio_cmd_reg != 16'h0000)
        |=> drive_o.src == DCR_SRC_RATIO)
        else $error("ratio reference not selected");

    a_hz_over_speed: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (frequency_ratio_cmd_reg == 16'h0000
         && frequency_hz_cmd_reg != 16'h0000)
        |=> drive_o.src == DCR_SRC_HZ)
        else $error("hertz reference not selected");

    a_freq_clamped: assert property (
        @(posedge clock_i) disable iff (reset_i)
        1'b1 |=> (drive_o.freq <= $past(limit_s))
              && (drive_o.freq >= -$past(limit_s)))
        else $error("frequency exceeds limit");

    a_pid_neg_zero: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (PID_NEG_ZERO && pid_setpoint_cmd_reg[15]) |=> drive_o.pid == 16'h0000)
        else $error("negative PID setpoint passed");

    a_read_back: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_req_i && rd_index_i == `DCR_IDX_FREQ_RATIO)
        |=> rd_ack_o && rdata_o == $past(frequency_ratio_cmd_reg))
        else $error("ratio read back differs");

    a_clear_reads_zero: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_req_i && rd_index_i == `DCR_IDX_FAULT_CLEAR)
        |=> rd_ack_o && rdata_o == 16'h0000)
        else $error("fault clear read not zero");

    a_run_clear_pulse: assert property (
        @(posedge clock_i) disable iff (reset_i)
        run_clear_req |=> fault_clear_o)
        else $error("run word clear did not pulse");

    a_clear_gated: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!link_ctrl_reg && !cmd_clear_req && !fault_clear_o) |=> !fault_clear_o)
        else $error("fault clear without link control");

    a_hold_refused: assert property (
        @(posedge clock_i) disable iff (reset_i)
        !term_active[`DCR_FUNC_STOP_HOLD] |=> !func_o[`DCR_FUNC_STOP_HOLD])
        else $error("stop hold taken from link");

    a_le_default_on: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!term_assigned[`DCR_FUNC_LINK_EN] && cfg_i.link_function_setting
         && cfg_i.bus_function_setting && cfg_i.loader_link_setting)
        |=> link_ctrl_reg)
        else $error("link enable default not on");
endmodule

// *** dcr_host_model.sv ***
`timescale 1ns/1ps
module dcr_host_model (
    // Clock
    input  wire logic          clock_i,
    // Link requests
    output dcr_pkg::dcr_wr_s   wr_o,
    output logic               rd_req_o,
    output logic [7:0]         rd_index_o,
    // Read answer
    input  wire logic [15:0]   rdata_i,
    input  wire logic          rd_ack_i
);
    import dcr_pkg::*;

    // Idle bus at time zero
    initial
    begin
        wr_o       = '0;
        rd_req_o   = 1'b0;
        rd_index_o = 8'h00;
    end

    // One write, valid for one edge; stale data inverted after release
    task automatic write(input logic [7:0] idx, input logic [15:0] val);
        @(posedge clock_i);
        wr_o <= '{valid: 1'b1, index: idx, data: val};
        @(posedge clock_i);
        wr_o.valid <= 1'b0;
        wr_o.data  <= ~val;
    endtask

    // One read; answer taken the cycle after the request
    task automatic read(input logic [7:0] idx, output logic [15:0] val,
                        output logic ack);
        @(posedge clock_i);
        rd_req_o   <= 1'b1;
        rd_index_o <= idx;
        @(posedge clock_i);
        rd_req_o   <= 1'b0;
        rd_index_o <= ~idx;
        @(posedge clock_i);
        ack = rd_ack_i;
        val = rdata_i;
    endtask

    // Fault clear by the run word: run bits dropped first, so no restart
    task automatic run_word_clear;
        write(8'h06, 16'h8000);
        write(8'h06, 16'h0000);
    endtask
endmodule

// *** drive_command_registers_bench.sv ***
`timescale 1ns/1ps
`include "dcr_defines.svh"
module drive_command_registers_bench;
    import dcr_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    localparam int NB = 11;
    localparam int NF = 64;
    localparam int CC = 4;
    logic                 clock_i;
    logic                 reset_i;
    logic                 rd_req_i;
    logic                 rd_ack_o;
    logic [7:0]           rd_index_i;
    logic [15:0]          rdata_o;
    logic [15:0]          rv;
    logic                 ack;
    dcr_wr_s              wr_i;
    dcr_cfg_s             cfg_i;
    logic [NB-1:0][7:0]   codes_i;
    logic [NB-1:0]        terminal_i;
    dcr_drive_s           drive_o;
    logic [NF-1:0]        func_o;
    logic                 forward_run_bit;
    logic                 reverse_run_bit;
    logic                 lce;
    logic                 fclr;
    int                   errors;
    int                   checks_done;
    logic [7:0]           idx [6];

    // Clock, 4 ns period
    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    dcr_top #(
        .NBITS        (NB),
        .NFUNC        (NF),
        .CLEAR_CYCLES (CC),
        .PID_NEG_ZERO (1'b1)
    ) dut_u (
        .clock_i               (clock_i),
        .reset_i               (reset_i),
        .wr_i                  (wr_i),
        .rd_req_i              (rd_req_i),
        .rd_index_i            (rd_index_i),
        .rdata_o               (rdata_o),
        .rd_ack_o              (rd_ack_o),
        .cfg_i                 (cfg_i),
        .codes_i               (codes_i),
        .terminal_i            (terminal_i),
        .drive_o               (drive_o),
        .forward_run_bit_o     (forward_run_bit),
        .reverse_run_bit_o     (reverse_run_bit),
        .func_o                (func_o),
        .link_control_enable_o (lce),
        .fault_clear_o         (fclr)
    );

    dcr_host_model host_u (
        .clock_i    (clock_i),
        .wr_o       (wr_i),
        .rd_req_o   (rd_req_i),
        .rd_index_o (rd_index_i),
        .rdata_i    (rdata_o),
        .rd_ack_i   (rd_ack_o)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t %s: %0h not %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] i, input logic [15:0] exp);
        host_u.read(i, rv, ack);
        check({31'h0, ack}, 32'h1, "read ack");
        check({16'h0, rv}, {16'h0, exp}, "read data");
    endtask

    // Count cycles of the timed clear pulse
    task automatic pulses(input int exp);
        int n;
        n = 0;
        // First sample in the cycle the write edge launched the pulse
        repeat (CC + 6)
        begin
            #1;
            if (fclr !== 1'b0)
                n++;
            @(posedge clock_i);
        end
        check(n, exp, "clear pulse length");
    endtask

    task automatic settle;
        repeat (3) @(posedge clock_i);
        #1;
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard, far beyond the roughly 155 cycles expected
    initial
    begin
        #20000;
        errors++;
        conclude;
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        errors      = 0;
        checks_done = 0;
        idx = '{`DCR_IDX_FREQ_RATIO, `DCR_IDX_FREQ_HZ, `DCR_IDX_RUN_WORD,
                `DCR_IDX_PID, `DCR_IDX_FAULT_CLEAR, `DCR_IDX_SPEED};
        reset_i    = 1'b1;
        cfg_i      = '{1'b0, 1'b0, 1'b0, 16'd6000, 16'd5000};
        codes_i    = {NB{8'hff}};
        terminal_i = '0;
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        // Reset values, readback of last written words
        foreach (idx[i]) rdchk(idx[i], 16'h0000);
        host_u.write(idx[0], 16'h8000);
        host_u.write(idx[1], 16'h04d2);
        host_u.write(idx[2], 16'h2000);
        host_u.write(idx[3], 16'hfff0);
        host_u.write(idx[5], 16'h0bb8);
        host_u.write(idx[4], 16'h0001);
        pulses(CC);
        host_u.write(idx[4], 16'h0002);
        pulses(0);
        rdchk(idx[0], 16'h8000);
        rdchk(idx[1], 16'h04d2);
        rdchk(idx[2], 16'h2000);
        rdchk(idx[3], 16'hfff0);
        rdchk(idx[4], 16'h0000);
        rdchk(idx[5], 16'h0bb8);
        rdchk(8'h02, 16'h0000);
        $display("test registers done");
        // Source precedence, scaling and clamping
        settle;
        check(drive_o.src, DCR_SRC_RATIO, "ratio wins");
        check(drive_o.freq, -17'sd5000, "negative clamp");
        check(drive_o.pid, 16'h0000, "pid negative");
        host_u.write(idx[0], 16'd20000);
        settle;
        check(drive_o.freq, 17'sd5000, "full scale clamp");
        host_u.write(idx[0], 16'd10000);
        settle;
        check(drive_o.freq, 17'sd3000, "half scale");
        host_u.write(idx[0], 16'h0000);
        settle;
        check(drive_o.src, DCR_SRC_HZ, "hertz wins");
        check(drive_o.freq, 17'sd1234, "hertz value");
        host_u.write(idx[1], 16'h0000);
        settle;
        check(drive_o.src, DCR_SRC_SPEED, "speed used");
        check(drive_o.speed, 16'h0bb8, "speed value");
        $display("test references done");
        // Run word fault clear, with and without link control
        host_u.run_word_clear;
        pulses(0);
        cfg_i <= '{1'b1, 1'b1, 1'b1, 16'd6000, 16'd5000};
        settle;
        check(lce, 1'b1, "link enable default");
        host_u.run_word_clear;
        pulses(CC);
        $display("test fault clear done");
        // Input functions from link and terminal block
        codes_i[0] <= 8'd5;
        codes_i[1] <= 8'd6;
        codes_i[2] <= 8'd0;
        codes_i[3] <= 8'd24;
        terminal_i <= 11'h008;
        host_u.write(idx[2], 16'h001d);
        settle;
        check(lce, 1'b1, "link enable on");
        check({forward_run_bit, reverse_run_bit}, 2'b10, "run bits");
        check(func_o[0], 1'b1, "link select");
        check(func_o[5], 1'b1, "link ramp select");
        check(func_o[6], 1'b0, "link stop hold");
        host_u.write(idx[2], 16'h0000);
        terminal_i <= 11'h00b;
        settle;
        check(func_o[5], 1'b0, "terminal ramp select");
        check(func_o[6], 1'b1, "terminal stop hold");
        terminal_i <= 11'h000;
        host_u.write(idx[2], 16'h0001);
        settle;
        check(lce, 1'b0, "link enable off");
        check(forward_run_bit, 1'b0, "run blocked");
        $display("test functions done");
        conclude;
    end
endmodule
